// ### rtl/supervisor_pkg.sv
/*
 * constants shared by the supervisor reset/watchdog logic: timing figures in their own
 * units, cycle counts derived from the reference clock, and state encodings.
 * assumes a single 100 MHz reference clock.
 */
package supervisor_pkg;

    localparam int unsigned CLK_PERIOD_PS      = 10_000;
    // reference cycles per microsecond; periods scale by this so no product leaves 32 bits
    localparam int unsigned CYCLES_PER_US      = 1_000_000 / CLK_PERIOD_PS;
    // hold period after the last reset cause goes away, in microseconds
    localparam int unsigned HOLD_PERIOD_US     = 200_000;
    localparam int unsigned HOLD_CYCLES        = HOLD_PERIOD_US * CYCLES_PER_US;
    // watchdog timeout, in microseconds
    localparam int unsigned WDOG_PERIOD_US     = 1_600_000;
    localparam int unsigned WDOG_CYCLES        = WDOG_PERIOD_US * CYCLES_PER_US;
    // self-service pulse: high for the final eighth, low for the first seven eighths
    localparam int unsigned SELF_LOW_NUM       = 7;
    localparam int unsigned SELF_DEN           = 8;
    // self-service period, in microseconds
    localparam int unsigned SELF_PERIOD_US     = 1_400_000;
    localparam int unsigned SELF_CYCLES        = SELF_PERIOD_US * CYCLES_PER_US;
    // shortest kick pulse that must register, in picoseconds
    localparam int unsigned KICK_MIN_PS        = 50_000;
    localparam int unsigned KICK_MIN_CYCLES    = KICK_MIN_PS / CLK_PERIOD_PS;
    // manual input must stay high this long before it counts as released (debounce)
    localparam int unsigned DEBOUNCE_US        = 10_000;
    localparam int unsigned DEBOUNCE_CYCLES    = DEBOUNCE_US * CYCLES_PER_US;
    // supply low must persist this long before it counts (glitch filter at zero overdrive)
    localparam int unsigned GLITCH_NS          = 100;
    localparam int unsigned GLITCH_CYCLES      = (GLITCH_NS * 1_000) / CLK_PERIOD_PS;

    localparam int unsigned CNT_W              = 32;
    localparam logic        RESET_ASSERTED_N   = 1'b0;

    typedef enum logic [1:0] {
        ST_ASSERT,
        ST_HOLD,
        ST_RUN
    } rst_state_t;

endpackage : supervisor_pkg

// ### rtl/kick_edge_detect.sv
/*
 * edge detector for the watchdog kick: picks the external kick or the self-service
 * waveform and flags any rising or falling edge for one cycle.
 * assumes the kick source is synchronous to ref_clk.
 */
`timescale 1ns/100ps
module kick_edge_detect
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // kick sources
    input  wire logic kick_ext,
    input  wire logic kick_self,
    input  wire logic kick_floating,
    // result
    output logic      toggle_pulse
);

    logic kick_sel;
    logic kick_reg;

    assign kick_sel = kick_floating ? kick_self : kick_ext;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            kick_reg <= 1'b0;
        else
            kick_reg <= kick_sel;
    end

    // both edge directions count; any level held one cycle (10 ns) is caught
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            toggle_pulse <= 1'b0;
        else
            toggle_pulse <= kick_sel ^ kick_reg;
    end

endmodule : kick_edge_detect

// ### rtl/supervisor_reset_watchdog.sv
/*
 * supervisor: combines supply-low, manual reset and watchdog timeout into a stretched
 * reset output pair, plus a watchdog with internal self-service when the kick floats.
 * assumes supply_low_in comes from an external comparator, synchronous to ref_clk,
 * and that kick_floating_in reflects an undriven kick pin.
 */
`timescale 1ns/100ps

// How it works
// - reset held while supply low, then held one hold period after recovery
// - supply falling low during operation asserts reset at once if deep, after GLITCH_CYCLES if not
// - every reset lasts at least a full hold period
// - each supply-low that gets past the glitch filter restarts the hold timer from zero
// - active-high reset output is always the exact inverse of active-low
// - low manual reset input asserts reset
// - reset held while manual input low, then one debounce spell plus one hold period after
// - manual input debounced so switch chatter gives one clean reset
// - kick not toggled within watchdog timeout asserts reset
// - watchdog timer cleared on reset and on any kick toggle
// - kick pulses as short as 50 ns are taken as toggles
// - watchdog stays cleared during reset, counts right after release
// - floating kick input effectively disables the watchdog
// - self-service drives kick low first 7/8, high last 1/8
// - self-service clears the watchdog every 1.4 s, never expiring
// - short supply-low glitches ignored, tolerance shrinking with depth
// - watchdog-caused reset held for the full hold period
// - both rising and falling kick edges count as toggles
module supervisor_reset_watchdog
#(
    parameter int unsigned HOLD_CYCLES     = supervisor_pkg::HOLD_CYCLES,
    parameter int unsigned WDOG_CYCLES     = supervisor_pkg::WDOG_CYCLES,
    parameter int unsigned SELF_CYCLES     = supervisor_pkg::SELF_CYCLES,
    parameter int unsigned DEBOUNCE_CYCLES = supervisor_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned GLITCH_CYCLES   = supervisor_pkg::GLITCH_CYCLES
)
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // supply monitor
    input  wire logic supply_low_in,
    input  wire logic supply_deep_in,
    // manual reset
    input  wire logic manual_reset_n_in,
    // watchdog kick
    input  wire logic watchdog_kick_in,
    input  wire logic kick_floating_in,
    // self-service drive onto the kick pin
    output logic      kick_self_out,
    output logic      kick_self_oe,
    // reset outputs
    output logic      reset_n_out,
    output logic      reset_out
);

    // last value of each counter, one below its period since counting starts at zero; SELF_HIGH is the self-service high threshold
    localparam logic [31:0] HOLD_LAST   = 32'(HOLD_CYCLES - 1);
    localparam logic [31:0] WDOG_LAST   = 32'(WDOG_CYCLES - 1);
    localparam logic [31:0] SELF_LAST   = 32'(SELF_CYCLES - 1);
    localparam logic [31:0] SELF_HIGH   =
        32'((SELF_CYCLES * supervisor_pkg::SELF_LOW_NUM) / supervisor_pkg::SELF_DEN);
    localparam logic [31:0] DEB_LAST    = 32'(DEBOUNCE_CYCLES - 1);
    localparam logic [31:0] GLITCH_LAST = 32'(GLITCH_CYCLES - 1);

    supervisor_pkg::rst_state_t state_reg;

    logic [31:0] glitch_cnt_reg;
    logic        supply_bad_reg;
    logic [31:0] deb_cnt_reg;
    logic        manual_bad_reg;
    logic [31:0] wdog_cnt_reg;
    logic        wdog_trip_reg;
    logic [31:0] self_cnt_reg;
    logic [31:0] hold_cnt_reg;
    logic        toggle_pulse;
    logic        cause_active;
    logic        in_reset;

    ////////////////////////////////////////////////////////////////////////////////
    // counter helpers, shared by every timer below

    // the end test uses >= so a counter that somehow overshoots still stops
    function automatic logic count_done
    (
        input logic [31:0] count,
        input logic [31:0] last
    );
        return (count >= last);
    endfunction : count_done

    // wraps at 32 bits; every limit in use sits far below that
    function automatic logic [31:0] count_up
    (
        input logic [31:0] count
    );
        return count + 32'h0000_0001;
    endfunction : count_up

    ////////////////////////////////////////////////////////////////////////////////
    // supply glitch filter

    // a low must persist GLITCH_CYCLES to count; a deep dip counts at once, so
    // the tolerated glitch width shrinks as overdrive grows
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            glitch_cnt_reg <= 32'h0000_0000;
            supply_bad_reg <= 1'b1;
        end
        else if (!supply_low_in)
        begin
            glitch_cnt_reg <= 32'h0000_0000;
            supply_bad_reg <= 1'b0;
        end
        // the count parks at its limit while the low persists
        else if (supply_deep_in || count_done(glitch_cnt_reg, GLITCH_LAST))
        begin
            supply_bad_reg <= 1'b1;
        end
        else
        begin
            glitch_cnt_reg <= count_up(glitch_cnt_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // manual reset debounce

    // assert on the first low, release only after a quiet high spell; chatter
    // restarts the spell so one press yields one reset; a low shorter than one
    // clock period may slip between two samples and go unseen
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            deb_cnt_reg    <= 32'h0000_0000;
            manual_bad_reg <= 1'b0;
        end
        else if (!manual_reset_n_in)
        begin
            deb_cnt_reg    <= 32'h0000_0000;
            manual_bad_reg <= 1'b1;
        end
        else if (manual_bad_reg)
        begin
            if (count_done(deb_cnt_reg, DEB_LAST))
            begin
                manual_bad_reg <= 1'b0;
                deb_cnt_reg    <= 32'h0000_0000;
            end
            else
            begin
                deb_cnt_reg <= count_up(deb_cnt_reg);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // self-service waveform: low for seven eighths, high for the last eighth
    // the counter runs whether or not the pin floats, so a release of the pin
    // picks up mid-period; both edges still come well inside one watchdog period

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            self_cnt_reg <= 32'h0000_0000;
        else if (count_done(self_cnt_reg, SELF_LAST))
            self_cnt_reg <= 32'h0000_0000;
        else
            self_cnt_reg <= count_up(self_cnt_reg);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            kick_self_out <= 1'b0;
            kick_self_oe  <= 1'b0;
        end
        else
        begin
            kick_self_out <= count_done(self_cnt_reg, SELF_HIGH);
            kick_self_oe  <= kick_floating_in;
        end
    end

    // a floating pin is never looked at: the detector follows the self-service
    // waveform instead, so pin noise cannot fake a kick
    kick_edge_detect i_kick_edge_detect
    (
        .ref_clk      (ref_clk),
        .arst_n       (arst_n),
        .kick_ext     (watchdog_kick_in),
        .kick_self    (kick_self_out),
        .kick_floating(kick_floating_in),
        .toggle_pulse (toggle_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog timer

    assign in_reset = (state_reg != supervisor_pkg::ST_RUN);

    // the trip flag is consumed by the reset state machine on the next edge;
    // the counter is held clear while reset is out, so it cannot retrip early
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wdog_cnt_reg  <= 32'h0000_0000;
            wdog_trip_reg <= 1'b0;
        end
        else if (in_reset || toggle_pulse)
        begin
            wdog_cnt_reg  <= 32'h0000_0000;
            wdog_trip_reg <= 1'b0;
        end
        // trips after a full period of counted cycles with no toggle
        else if (count_done(wdog_cnt_reg, WDOG_LAST))
        begin
            wdog_cnt_reg  <= 32'h0000_0000;
            wdog_trip_reg <= 1'b1;
        end
        else
        begin
            wdog_cnt_reg  <= count_up(wdog_cnt_reg);
            wdog_trip_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset sequencer

    // one pass through the assert state after the last cause lets every cause
    // share a single hold count, at the cost of one extra cycle of reset
    assign cause_active = supply_bad_reg || manual_bad_reg;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg    <= supervisor_pkg::ST_ASSERT;
            hold_cnt_reg <= 32'h0000_0000;
        end
        else if (cause_active)
        begin
            state_reg    <= supervisor_pkg::ST_ASSERT;
            hold_cnt_reg <= 32'h0000_0000;
        end
        else
        begin
            unique case (state_reg)
                supervisor_pkg::ST_ASSERT:
                begin
                    state_reg    <= supervisor_pkg::ST_HOLD;
                    hold_cnt_reg <= 32'h0000_0000;
                end
                supervisor_pkg::ST_HOLD:
                begin
                    if (count_done(hold_cnt_reg, HOLD_LAST))
                        state_reg <= supervisor_pkg::ST_RUN;
                    else
                        hold_cnt_reg <= count_up(hold_cnt_reg);
                end
                supervisor_pkg::ST_RUN:
                begin
                    if (wdog_trip_reg)
                    begin
                        state_reg    <= supervisor_pkg::ST_HOLD;
                        hold_cnt_reg <= 32'h0000_0000;
                    end
                end
                // the unused fourth code falls back to asserting reset
                default:
                begin
                    state_reg    <= supervisor_pkg::ST_ASSERT;
                    hold_cnt_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // both outputs from flops updated on the same edge, so they never disagree;
    // the cause term asserts reset one cycle sooner than waiting for the state
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reset_n_out <= supervisor_pkg::RESET_ASSERTED_N;
            reset_out   <= ~supervisor_pkg::RESET_ASSERTED_N;
        end
        else
        begin
            reset_n_out <= !(in_reset || cause_active);
            reset_out   <= (in_reset || cause_active);
        end
    end

endmodule : supervisor_reset_watchdog

// ### test/reset_watch_chk.sv
/*
 * checker for reset stretching, watchdog and self-service timing.
 * assumes the bind hands on the shortened counts.
 */
`timescale 1ns/100ps
module reset_watch_chk
#(
    parameter int unsigned HOLD_CYCLES = 50,
    parameter int unsigned WDOG_CYCLES = 400,
    parameter int unsigned SELF_CYCLES = 350,
    parameter int unsigned GLITCH_CYCLES = 3,
    parameter int unsigned DEBOUNCE_CYCLES = 5
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // causes
    input wire logic supply_low_in,
    input wire logic supply_deep_in,
    input wire logic manual_reset_n_in,
    input wire logic watchdog_kick_in,
    input wire logic kick_floating_in,
    // outputs
    input wire logic kick_self_out,
    input wire logic reset_n_out,
    input wire logic reset_out
);
localparam int unsigned REL_MAX = HOLD_CYCLES + DEBOUNCE_CYCLES + 12;
localparam int unsigned SELF_HI = SELF_CYCLES / 8 + 3;
int unsigned low_cnt, quiet_cnt, sup_run, hi_cnt, since_kick, idle_cnt;
logic        kick_q;
logic        edge_seen;
logic        cause;
// a filtered supply dip is no cause, so it must not restart the quiet count
assign cause = !manual_reset_n_in
    || (supply_low_in && (supply_deep_in || sup_run + 1 >= GLITCH_CYCLES));
assign edge_seen = watchdog_kick_in != kick_q;
always_ff @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        {low_cnt, quiet_cnt, sup_run, hi_cnt, since_kick, idle_cnt} <= '0;
        kick_q <= 1'b0;
    end
    else
    begin
        low_cnt <= reset_n_out ? 0 : low_cnt + 1;
        quiet_cnt <= cause ? 0 : quiet_cnt + 1;
        sup_run <= supply_low_in ? sup_run + 1 : 0;
        hi_cnt <= kick_self_out ? hi_cnt + 1 : 0;
        since_kick <= (!reset_n_out || edge_seen) ? 0 : since_kick + 1;
        idle_cnt <= (!reset_n_out || edge_seen || kick_floating_in) ? 0 : idle_cnt + 1;
        kick_q <= watchdog_kick_in;
    end
end
default clocking cb @(posedge ref_clk);
endclocking
default disable iff (!arst_n);
property p_inverse; reset_out == !reset_n_out; endproperty
property p_deep; supply_low_in && supply_deep_in |-> ##[1:3] !reset_n_out; endproperty
property p_manual; !manual_reset_n_in |-> ##[1:3] !reset_n_out; endproperty
property p_hold_min; $rose(reset_n_out) |-> low_cnt >= HOLD_CYCLES; endproperty
property p_rel_late; $rose(reset_n_out) |-> quiet_cnt >= HOLD_CYCLES; endproperty
property p_rel_bound; quiet_cnt == REL_MAX |-> reset_n_out; endproperty
property p_wdog_bound; idle_cnt <= WDOG_CYCLES + 6; endproperty
property p_no_early;
    $fell(reset_n_out) && quiet_cnt > 6 |-> since_kick + 6 >= WDOG_CYCLES;
endproperty
property p_self_high; hi_cnt <= SELF_HI; endproperty
a_inverse: assert property (p_inverse) else $error("outputs not inverse");
a_deep: assert property (p_deep) else $error("brownout missed");
a_manual: assert property (p_manual) else $error("manual missed");
a_hold_min: assert property (p_hold_min) else $error("reset too short");
a_rel_late: assert property (p_rel_late) else $error("released early");
a_rel_bound: assert property (p_rel_bound) else $error("released late");
a_wdog_bound: assert property (p_wdog_bound) else $error("no trip");
a_no_early: assert property (p_no_early) else $error("early trip");
a_self_high: assert property (p_self_high) else $error("self high long");
c_manual: cover property (!manual_reset_n_in ##2 !reset_n_out);
c_trip: cover property ($fell(reset_n_out) && quiet_cnt > 6);
c_self: cover property ($fell(kick_self_out));
endmodule : reset_watch_chk

bind supervisor_reset_watchdog reset_watch_chk #(
    .HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES), .SELF_CYCLES(SELF_CYCLES),
    .GLITCH_CYCLES(GLITCH_CYCLES), .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) i_reset_watch_chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .supply_low_in(supply_low_in),
    .supply_deep_in(supply_deep_in), .manual_reset_n_in(manual_reset_n_in),
    .watchdog_kick_in(watchdog_kick_in), .kick_floating_in(kick_floating_in),
    .kick_self_out(kick_self_out), .reset_n_out(reset_n_out), .reset_out(reset_out)
);

// ### test/host_kick_model.sv
/*
 * host side of the kick pin: pulses, level toggles, stuck, or released.
 * assumes the bench resolves the pin from both drivers.
 */
`timescale 1ns/100ps
module host_kick_model
(
    // clock and reset seen by the host
    input  wire logic        ref_clk,
    input  wire logic        reset_n_out,
    // control: mode 0 pulse, 1 level toggle, 2 stuck
    input  wire logic        drive_en,
    input  wire logic [1:0]  mode,
    input  wire logic [15:0] period,
    // pin drive
    output logic             host_kick,
    output logic             host_drive
);
int unsigned cnt;
initial
begin
    host_kick = 1'b0;
    host_drive = 1'b0;
    cnt = 0;
end
always @(negedge ref_clk)
begin
    host_drive <= drive_en;
    if (!drive_en || !reset_n_out)
    begin
        cnt <= 0;
        host_kick <= 1'b0;
    end
    else
    begin
        cnt <= (cnt >= period) ? 0 : cnt + 1;
        if (mode == 2'd0)
            host_kick <= cnt < 5;
        else if (mode == 2'd1 && cnt == period)
            host_kick <= !host_kick;
    end
end
endmodule : host_kick_model

// ### test/supervisor_reset_watchdog_tb.sv
/*
 * bench for the supervisor: power-up, brownout, glitches, manual press,
 * watchdog service and trip, floating kick. assumes the checker is bound.
 */
`timescale 1ns/100ps
module supervisor_reset_watchdog_tb;
localparam int unsigned HOLD = 50;
localparam int unsigned WDOG = 400;
localparam int unsigned SELF = 350;
localparam int unsigned DEB = 5;
localparam int unsigned GLT = 3;
logic        ref_clk, arst_n, supply_low_in, supply_deep_in, manual_reset_n_in;
logic        drive_en, junk, host_kick, host_drive;
logic [1:0]  mode;
logic [15:0] period;
logic        kick_self_out, kick_self_oe, reset_n_out, reset_out;
int unsigned num_errors, check_count, n, run, top;
wire logic   kick_floating_in = !host_drive;
// an undriven pin with no pull must not look stable
wire logic   watchdog_kick_in = host_drive ? host_kick : (kick_self_oe ? kick_self_out : junk);
supervisor_reset_watchdog #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG), .SELF_CYCLES(SELF),
    .DEBOUNCE_CYCLES(DEB), .GLITCH_CYCLES(GLT)) i_supervisor_reset_watchdog (
    .ref_clk(ref_clk), .arst_n(arst_n), .supply_low_in(supply_low_in),
    .supply_deep_in(supply_deep_in), .manual_reset_n_in(manual_reset_n_in),
    .watchdog_kick_in(watchdog_kick_in), .kick_floating_in(kick_floating_in),
    .kick_self_out(kick_self_out), .kick_self_oe(kick_self_oe),
    .reset_n_out(reset_n_out), .reset_out(reset_out));
host_kick_model i_host_kick_model (.ref_clk(ref_clk), .reset_n_out(reset_n_out),
    .drive_en(drive_en), .mode(mode), .period(period), .host_kick(host_kick),
    .host_drive(host_drive));
task automatic check(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
        num_errors++;
        $display("mismatch %s expected %b seen %b", what, exp, got);
    end
endtask : check
task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask : tally_and_finish
task automatic cyc(input int unsigned k);
    repeat (k) @(negedge ref_clk);
endtask : cyc
task automatic wait_rst(input logic lvl, input int unsigned lim);
    n = 0;
    while (reset_n_out !== lvl && n < lim)
    begin
        cyc(1);
        n++;
    end
    if (reset_n_out !== lvl)
    begin
        num_errors++;
        $display("mismatch reset_n_out wait expected %b seen %b", lvl, reset_n_out);
        tally_and_finish();
    end
endtask : wait_rst
task automatic dip(input int unsigned len, input logic deep);
    supply_low_in = 1'b1;
    supply_deep_in = deep;
    cyc(len);
    supply_low_in = 1'b0;
    supply_deep_in = 1'b0;
endtask : dip
task automatic bounce();
    repeat (10)
    begin
        manual_reset_n_in = 1'($urandom_range(0, 1));
        cyc(1);
    end
endtask : bounce
function automatic int unsigned rel_max(input int unsigned extra);
    return HOLD + extra + GLT + 8;
endfunction : rel_max
initial
begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
end
always @(negedge ref_clk) junk <= ~junk;
initial
begin
    {arst_n, supply_low_in, supply_deep_in, junk} = '0;
    manual_reset_n_in = 1'b1;
    drive_en = 1'b1;
    mode = 2'd0;
    period = 16'd200;
    num_errors = 0;
    check_count = 0;
    void'($urandom(32'hcdc4b1cd));
    cyc(3);
    check("reset_out", 1'b1, reset_out);
    arst_n = 1'b1;
    wait_rst(1'b1, rel_max(0));
    check("power-up hold", 1'b1, n >= HOLD);
    dip(1, 1'b1);
    cyc(3);
    check("brownout", 1'b0, reset_n_out);
    cyc(20);
    dip(1, 1'b1);
    wait_rst(1'b1, rel_max(0));
    check("hold restart", 1'b1, n >= HOLD);
    for (int i = 0; i < 4; i++)
    begin
        run = (i % 2) ? $urandom_range(8, 20) : $urandom_range(1, 2);
        dip(run, 1'b0);
        cyc(3);
        check("glitch", run < GLT, reset_n_out);
        wait_rst(1'b1, rel_max(0));
    end
    manual_reset_n_in = 1'b0;
    cyc(3);
    check("manual press", 1'b0, reset_n_out);
    bounce();
    manual_reset_n_in = 1'b0;
    cyc(80);
    check("manual held", 1'b0, reset_n_out);
    bounce();
    // end the chatter on a low so the hold is measured from a known last press
    manual_reset_n_in = 1'b0;
    cyc(1);
    manual_reset_n_in = 1'b1;
    wait_rst(1'b1, rel_max(DEB));
    check("manual release", 1'b1, n >= HOLD);
    cyc(30);
    check("one clean reset", 1'b1, reset_n_out);
    for (int i = 0; i < 4; i++)
    begin
        period <= 16'($urandom_range(20, 300));
        cyc(700);
        check("kicked", 1'b1, reset_n_out);
    end
    mode <= 2'd1;
    period <= 16'd300;
    cyc(1300);
    check("single edges", 1'b1, reset_n_out);
    mode <= 2'd2;
    wait_rst(1'b0, WDOG + 10);
    wait_rst(1'b1, rel_max(0));
    check("trip hold", 1'b1, n >= HOLD);
    mode <= 2'd0;
    drive_en <= 1'b0;
    cyc(3);
    check("self drive", 1'b1, kick_self_oe);
    run = 0;
    top = 0;
    repeat (3 * WDOG)
    begin
        cyc(1);
        run = kick_self_out ? run + 1 : 0;
        top = (run > top) ? run : top;
        check("floating", 1'b1, reset_n_out);
    end
    check("self high", 1'b1, top >= SELF / 8 - 2 && top <= SELF / 8 + 2);
    tally_and_finish();
end
endmodule : supervisor_reset_watchdog_tb
